// File: core/ep_ctrl_bank.sv
// sixteen endpoint control registers with hardware-set stall flags
`timescale 1ns/1ps
module ep_ctrl_bank (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // software write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    // stall events from the serial engine, one pulse per endpoint
    input wire logic [usb_cfg_pkg::EP_COUNT-1:0] stall_set,
    // stored register contents
    output usb_cfg_pkg::ep_ctrl_s ep_q [usb_cfg_pkg::EP_COUNT]
);
    import usb_cfg_pkg::*;

    // unimplemented bit 5 never stores
    wire [7:0] wr_masked = wr_data & EP_IMPL_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // one register per endpoint, identical layout
    genvar gi;
    generate
        for (gi = 0; gi < EP_COUNT; gi++) begin : g_ep
            wire hit = wr_en && (wr_idx == 4'(gi));
            ep_ctrl_s ep_d;
            always_comb begin
                ep_d = hit ? ep_ctrl_s'(wr_masked) : ep_q[gi];
                // a stall event wins over a clearing write in the same cycle
                ep_d.endpoint_stall_flag = ep_d.endpoint_stall_flag | stall_set[gi];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ep_q[gi] <= ep_ctrl_s'(REG_RST);
                end else begin
                    ep_q[gi] <= ep_d;
                end
            end
        end
    endgenerate

endmodule

// File: core/pin_sync.sv
// two-flop synchroniser for the system power mode pins
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous levels in, synchronised levels out
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out
);
    import usb_cfg_pkg::*;

    logic [1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 2'h0;
            pin_out <= 2'h0;
        end else begin
            meta_q <= pin_in;
            pin_out <= meta_q;
        end
    end

endmodule

// File: core/usb_cfg_pkg.sv
// shared constants and types for the usb configuration and endpoint control block
package usb_cfg_pkg;

    // apb address map, byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] PWR_OFS = 8'h04;
    localparam logic [7:0] INT_STAT_OFS = 8'h08;
    localparam logic [7:0] INT_MASK_OFS = 8'h0C;
    localparam logic [1:0] EP_REGION = 2'h1;

    // configuration register fields
    localparam int CFG_EYE_BIT = 7;
    localparam int CFG_OEMON_BIT = 6;
    localparam int CFG_SIDL_BIT = 4;
    localparam int CFG_ASUSP_BIT = 0;
    localparam logic [7:0] CFG_IMPL_MASK = 8'hD1;

    // power control register fields
    localparam int PWR_SUSP_BIT = 1;
    localparam logic [7:0] PWR_IMPL_MASK = 8'h02;

    // endpoint control register
    localparam int EP_COUNT = 16;
    localparam logic [7:0] EP_IMPL_MASK = 8'hDF;

    // interrupt status and mask layout
    localparam int INT_W = 3;
    localparam int INT_SUSP_BIT = 0;
    localparam int INT_STALL_BIT = 1;
    localparam int INT_HALT_BIT = 2;

    // values after reset
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [INT_W-1:0] INT_RST = 3'h0;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // endpoint control byte, bit 7 down to bit 0
    typedef struct packed {
        logic low_speed_direct;
        logic nak_retry_disable;
        logic unused5;
        logic control_transfer_disable;
        logic endpoint_receive_enable;
        logic endpoint_transmit_enable;
        logic endpoint_stall_flag;
        logic endpoint_handshake_enable;
    } ep_ctrl_s;

endpackage

// File: core/usb_config_endpoint_control.sv
// usb configuration, power and endpoint control registers with apb slave and interrupt
//
// Contract
// - config and endpoint bits 31..8 and unimplemented bits read zero.
// - config bit 7 turns the transceiver eye-pattern test on.
// - config bit 6 enables an output-enable indication while D+/D- are driven.
// - config bit 4 halts the module while the system is in Idle.
// - config bit 0 suspends the module automatically when the system sleeps.
// - without auto suspend only the suspend request bit suspends; suspend stops 48 MHz clock.
// - endpoint 0 bit 7 in host mode picks direct low-speed, else hub with preamble.
// - endpoint 0 bit 6 in host mode suppresses hardware retry of NAKed transactions.
// - with rx and tx enabled, bit 4 rejects SETUP transfers; otherwise ignored.
// - endpoint bit 3 allows or blocks reception.
// - endpoint bit 2 allows or blocks transmission.
// - endpoint bit 1 reads one once the endpoint has been stalled.
// - endpoint bit 0 enables handshake packets; clear for isochronous use.
`timescale 1ns/1ps
module usb_config_endpoint_control (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usb_cfg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system power mode pins, asynchronous
    input wire logic sys_idle,
    input wire logic sys_sleep,
    // serial engine status, same clock
    input wire logic host_mode,
    input wire logic xcvr_drive,
    input wire logic [usb_cfg_pkg::EP_COUNT-1:0] stall_set,
    // transceiver and clock control
    output logic eye_test_en,
    output logic oe_monitor,
    output logic module_halt,
    output logic module_suspend,
    output logic usb_clk_en,
    // host mode endpoint 0 control
    output logic host_ls_direct,
    output logic host_preamble,
    output logic host_nak_retry,
    // per endpoint permissions
    output logic [usb_cfg_pkg::EP_COUNT-1:0] ep_rx_allow,
    output logic [usb_cfg_pkg::EP_COUNT-1:0] ep_tx_allow,
    output logic [usb_cfg_pkg::EP_COUNT-1:0] ep_setup_accept,
    output logic [usb_cfg_pkg::EP_COUNT-1:0] ep_handshake_en,
    // interrupt
    output logic irq
);
    import usb_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] cfg_q;
    logic [7:0] pwr_q;
    logic [INT_W-1:0] int_stat_q;
    logic [INT_W-1:0] int_stat_d;
    logic [INT_W-1:0] int_mask_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic halt_q;
    logic suspend_q;
    logic clk_en_q;
    logic oe_mon_q;
    logic ls_direct_q;
    logic preamble_q;
    logic nak_retry_q;
    logic irq_q;
    logic [EP_COUNT-1:0] rx_allow_q;
    logic [EP_COUNT-1:0] tx_allow_q;
    logic [EP_COUNT-1:0] setup_q;
    logic [EP_COUNT-1:0] hshk_q;
    logic [1:0] pins_s;
    ep_ctrl_s ep_q [EP_COUNT];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, nothing reads the pins before them
    pin_sync pin_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({sys_sleep, sys_idle}),
        .pin_out(pins_s)
    );

    wire idle_s = pins_s[0];
    wire sleep_s = pins_s[1];

    ////////////////////////////////////////////////////////////////////////////
    // apb phases: one wait state so read data comes from a register
    wire acc_go = psel && penable && !pready_q;
    wire acc_done = psel && penable && pready_q;

    // address decode
    wire aligned = (paddr[1:0] == 2'h0);
    wire sel_cfg = (paddr == CFG_OFS);
    wire sel_pwr = (paddr == PWR_OFS);
    wire sel_stat = (paddr == INT_STAT_OFS);
    wire sel_mask = (paddr == INT_MASK_OFS);
    wire sel_ep = (paddr[7:6] == EP_REGION) && aligned;
    wire [3:0] ep_idx = paddr[5:2];
    wire mapped = sel_cfg || sel_pwr || sel_stat || sel_mask || sel_ep;

    // write strobes, effective only at the completing edge
    wire wr_ok = acc_done && pwrite && mapped;
    wire wr_cfg = wr_ok && sel_cfg;
    wire wr_pwr = wr_ok && sel_pwr;
    wire wr_mask = wr_ok && sel_mask;
    wire wr_ep = wr_ok && sel_ep;
    wire rd_stat = acc_done && !pwrite && sel_stat;

    // read selection, upper bits always zero
    wire [7:0] ep_rd = ep_q[ep_idx];
    wire [7:0] stat_rd = {5'h00, int_stat_q};
    wire [7:0] mask_rd = {5'h00, int_mask_q};
    wire [7:0] rd_byte = sel_cfg ? cfg_q :
                         sel_pwr ? pwr_q :
                         sel_stat ? stat_rd :
                         sel_mask ? mask_rd :
                         sel_ep ? ep_rd : 8'h00;
    wire [31:0] rd_word = {24'h00_0000, rd_byte};

    ////////////////////////////////////////////////////////////////////////////
    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= WORD_RST;
        end else begin
            pready_q <= acc_go;
            pslverr_q <= acc_go && !mapped;
            prdata_q <= (acc_go && !pwrite && mapped) ? rd_word : WORD_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration, power and mask registers; unimplemented bits never store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= REG_RST;
            pwr_q <= REG_RST;
            int_mask_q <= INT_RST;
        end else begin
            if (wr_cfg) begin
                cfg_q <= pwdata[7:0] & CFG_IMPL_MASK;
            end
            if (wr_pwr) begin
                pwr_q <= pwdata[7:0] & PWR_IMPL_MASK;
            end
            if (wr_mask) begin
                int_mask_q <= pwdata[INT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // endpoint register bank
    ep_ctrl_bank ep_ctrl_bank_inst (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ep),
        .wr_idx(ep_idx),
        .wr_data(pwdata[7:0]),
        .stall_set(stall_set),
        .ep_q(ep_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // power behaviour: idle halts, sleep or request suspends
    wire halt_d = cfg_q[CFG_SIDL_BIT] && idle_s;
    wire auto_susp = cfg_q[CFG_ASUSP_BIT] && sleep_s;
    wire suspend_d = pwr_q[PWR_SUSP_BIT] || auto_susp;
    // the 48 MHz clock is gated off whenever the module is not running
    wire clk_en_d = !suspend_d && !halt_d;
    wire oe_mon_d = cfg_q[CFG_OEMON_BIT] && xcvr_drive;

    // host path choices come from endpoint 0 only
    wire ls_bit = ep_q[0].low_speed_direct;
    wire retry_bit = ep_q[0].nak_retry_disable;
    wire ls_direct_d = host_mode && ls_bit;
    wire preamble_d = host_mode && !ls_bit;
    wire nak_retry_d = host_mode && !retry_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= 1'b0;
            suspend_q <= 1'b0;
            clk_en_q <= 1'b1;
            oe_mon_q <= 1'b0;
            ls_direct_q <= 1'b0;
            preamble_q <= 1'b0;
            nak_retry_q <= 1'b0;
        end else begin
            halt_q <= halt_d;
            suspend_q <= suspend_d;
            clk_en_q <= clk_en_d;
            oe_mon_q <= oe_mon_d;
            ls_direct_q <= ls_direct_d;
            preamble_q <= preamble_d;
            nak_retry_q <= nak_retry_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per endpoint permissions
    genvar gi;
    generate
        for (gi = 0; gi < EP_COUNT; gi++) begin : g_perm
            wire rx_en = ep_q[gi].endpoint_receive_enable;
            wire tx_en = ep_q[gi].endpoint_transmit_enable;
            // setup needs both directions; the disable bit is ignored otherwise
            wire setup_d = rx_en && tx_en && !ep_q[gi].control_transfer_disable;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_allow_q[gi] <= 1'b0;
                    tx_allow_q[gi] <= 1'b0;
                    setup_q[gi] <= 1'b0;
                    hshk_q[gi] <= 1'b0;
                end else begin
                    rx_allow_q[gi] <= rx_en;
                    tx_allow_q[gi] <= tx_en;
                    setup_q[gi] <= setup_d;
                    hshk_q[gi] <= ep_q[gi].endpoint_handshake_enable;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events: suspend entry, any stall, idle halt entry
    wire [INT_W-1:0] int_evt;
    assign int_evt[INT_SUSP_BIT] = suspend_d && !suspend_q;
    assign int_evt[INT_STALL_BIT] = |stall_set;
    assign int_evt[INT_HALT_BIT] = halt_d && !halt_q;

    // a read clears, but an event in the same cycle survives it
    always_comb begin
        int_stat_d = (rd_stat ? INT_RST : int_stat_q) | int_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= INT_RST;
            irq_q <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flip-flop
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign eye_test_en = cfg_q[CFG_EYE_BIT];
    assign oe_monitor = oe_mon_q;
    assign module_halt = halt_q;
    assign module_suspend = suspend_q;
    assign usb_clk_en = clk_en_q;
    assign host_ls_direct = ls_direct_q;
    assign host_preamble = preamble_q;
    assign host_nak_retry = nak_retry_q;
    assign ep_rx_allow = rx_allow_q;
    assign ep_tx_allow = tx_allow_q;
    assign ep_setup_accept = setup_q;
    assign ep_handshake_en = hshk_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_upper_zero: assert property (pready_q |-> prdata_q[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    chk_eye_write: assert property (wr_cfg |=> eye_test_en == $past(pwdata[CFG_EYE_BIT]))
        else $error("eye test enable does not follow config write");

    chk_oe_quiet: assert property (!cfg_q[CFG_OEMON_BIT] |=> !oe_monitor)
        else $error("oe indication active while monitor disabled");

    chk_idle_halt: assert property (module_halt |-> $past(cfg_q[CFG_SIDL_BIT]))
        else $error("halt without stop in idle set");

    chk_sleep_suspend: assert property (
        module_suspend && !$past(pwr_q[PWR_SUSP_BIT]) |-> $past(cfg_q[CFG_ASUSP_BIT] && sleep_s))
        else $error("suspend without request or auto suspend on sleep");

    chk_clk_stop: assert property (module_suspend |-> !usb_clk_en)
        else $error("usb clock running while suspended");

    chk_req_suspend: assert property (wr_pwr && pwdata[PWR_SUSP_BIT] |-> ##2 module_suspend)
        else $error("suspend request not honoured in two cycles");

    chk_ls_path: assert property ($past(host_mode) |-> host_ls_direct != host_preamble)
        else $error("low speed path not exclusive in host mode");

    chk_nak_retry: assert property (host_nak_retry |-> $past(host_mode && !retry_bit))
        else $error("nak retry active while disabled");

    chk_setup_gate: assert property (
        ep_setup_accept[0] |-> $past(ep_q[0].endpoint_receive_enable && ep_q[0].endpoint_transmit_enable))
        else $error("setup accepted without both directions enabled");

    chk_rx_block: assert property (!ep_q[1].endpoint_receive_enable |=> !ep_rx_allow[1])
        else $error("reception allowed while disabled");

    chk_tx_block: assert property (!ep_q[1].endpoint_transmit_enable |=> !ep_tx_allow[1])
        else $error("transmission allowed while disabled");

    chk_stall_sticky: assert property (stall_set[0] |=> ep_q[0].endpoint_stall_flag)
        else $error("stall event lost");

    chk_hshk_follow: assert property (
        wr_ep && ep_idx == 4'h2 |-> ##2 ep_handshake_en[2] == $past(pwdata[0], 2))
        else $error("handshake enable does not follow write");

    chk_irq_stall: assert property (stall_set[3] && int_mask_q[INT_STALL_BIT] ##1 int_mask_q[INT_STALL_BIT]
        |=> irq)
        else $error("unmasked stall did not raise interrupt");

    chk_stat_keep: assert property (rd_stat && (|stall_set) |=> int_stat_q[INT_STALL_BIT])
        else $error("stall event lost to a same-cycle status read");

    chk_err_with_ready: assert property (pslverr |-> pready && prdata == WORD_RST)
        else $error("error response without ready or with nonzero data");

    cov_ep_write: cover property (wr_ep ##2 ep_setup_accept[ep_idx]);
    cov_stall_irq: cover property (stall_set[5] ##[1:4] irq);
    cov_suspend: cover property ($rose(module_suspend) ##1 !usb_clk_en);
    cov_host_ls: cover property (host_mode ##1 host_ls_direct);

endmodule

// File: sim/serial_engine_model.sv
// behavioural serial engine: stall pulses and transceiver drive bursts
`timescale 1ns/1ps
module serial_engine_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requests from the bench
    input wire logic stall_go,
    input wire logic [3:0] stall_ep,
    input wire logic send,
    // towards the block
    output logic [15:0] stall_set,
    output logic xcvr_drive
);
    logic [3:0] burst_q;

    // one-cycle stall pulse, burst of eight drive cycles per send
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_set <= 16'h0000;
            burst_q <= 4'h0;
        end else begin
            stall_set <= stall_go ? (16'h0001 << stall_ep) : 16'h0000;
            burst_q <= send ? 4'h8 : (burst_q != 4'h0 ? burst_q - 4'h1 : 4'h0);
        end
    end
    // drive follows the burst counter, idle otherwise
    assign xcvr_drive = (burst_q != 4'h0);
endmodule

// File: sim/usb_config_endpoint_control_tb.sv
// self-checking bench for the usb configuration and endpoint control block
`timescale 1ns/1ps
module usb_config_endpoint_control_tb;
    import usb_cfg_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, sys_idle = 1'b0, sys_sleep = 1'b0, host_mode = 1'b0;
    logic xcvr_drive, stall_go = 1'b0, send = 1'b0, irq;
    logic [3:0] stall_ep = 4'h0;
    logic [15:0] stall_set, rxa, txa, sua, hse;
    logic eye, oem, halt, susp, clken, lsd, pre, nak;
    int num_errors = 0, checks_done = 0;

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    usb_config_endpoint_control usb_config_endpoint_control_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sys_idle(sys_idle), .sys_sleep(sys_sleep), .host_mode(host_mode),
        .xcvr_drive(xcvr_drive), .stall_set(stall_set), .eye_test_en(eye), .oe_monitor(oem), .module_halt(halt),
        .module_suspend(susp), .usb_clk_en(clken), .host_ls_direct(lsd), .host_preamble(pre),
        .host_nak_retry(nak), .ep_rx_allow(rxa), .ep_tx_allow(txa), .ep_setup_accept(sua),
        .ep_handshake_en(hse), .irq(irq));
    serial_engine_model serial_engine_model_inst (.pclk(pclk), .presetn(presetn), .stall_go(stall_go),
        .stall_ep(stall_ep), .send(send), .stall_set(stall_set), .xcvr_drive(xcvr_drive));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // apb transfer; the request holds until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // look just after each edge so the registered answer has settled
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            end_of_test();
        end
        // the answer stands for this whole cycle; the next edge completes the transfer
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // outputs lag pins by up to three cycles and irq by four, so settle four
    task automatic settle();
        repeat (4) @(posedge pclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        chk({eye, oem, halt, susp, clken, lsd, pre, nak, irq}, 9'h010);
        apb(1'b0, CFG_OFS, 32'h0); chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_cfg();
        apb(1'b1, CFG_OFS, 32'hFFFF_FFFF); apb(1'b0, CFG_OFS, 32'h0);
        chk(rd, 32'h0000_00D1);
        settle(); chk(eye, 1'b1);
        chk(oem, 1'b0);
        @(posedge pclk); send <= 1'b1; @(posedge pclk); send <= 1'b0;
        settle(); chk(oem, 1'b1);
        apb(1'b1, CFG_OFS, 32'h10);
        settle(); chk({eye, halt, clken}, 3'b001);
        @(posedge pclk); sys_idle <= 1'b1;
        settle(); chk({halt, clken}, 2'b10);
        apb(1'b1, CFG_OFS, 32'h00); settle(); chk({halt, clken}, 2'b01);
        @(posedge pclk); sys_idle <= 1'b0; sys_sleep <= 1'b1;
        settle(); chk(susp, 1'b0);
        apb(1'b1, CFG_OFS, 32'h01); settle(); chk({susp, clken}, 2'b10);
        apb(1'b1, CFG_OFS, 32'h00); settle(); chk(susp, 1'b0);
        apb(1'b1, PWR_OFS, 32'h02); settle(); chk({susp, clken}, 2'b10);
        apb(1'b1, PWR_OFS, 32'h00); @(posedge pclk); sys_sleep <= 1'b0;
        settle(); chk({susp, clken}, 2'b01);
        $display("test config done");
    endtask

    // every endpoint with a table of enable combinations
    task automatic t_ep();
        logic [7:0] v [5] = '{8'hFF, 8'h2D, 8'h1C, 8'h0A, 8'h00};
        logic [7:0] a;
        for (int i = 0; i < EP_COUNT; i++) begin
            a = {EP_REGION, i[3:0], 2'h0};
            for (int k = 0; k < 5; k++) begin
                apb(1'b1, a, {24'hFFFF_FF, v[k]}); apb(1'b0, a, 32'h0);
                chk(rd, {24'h0, v[k] & 8'hDF});
                settle();
                chk({rxa[i], txa[i], sua[i], hse[i]}, {v[k][3], v[k][2], v[k][3] & v[k][2] & ~v[k][4], v[k][0]});
            end
        end
        $display("test endpoints done");
    endtask

    task automatic t_host();
        @(posedge pclk); host_mode <= 1'b1;
        apb(1'b1, 8'h40, 32'h80); settle(); chk({lsd, pre, nak}, 3'b101);
        apb(1'b1, 8'h40, 32'h40); settle(); chk({lsd, pre, nak}, 3'b010);
        apb(1'b1, 8'h40, 32'h00); settle(); chk({lsd, pre, nak}, 3'b011);
        @(posedge pclk); host_mode <= 1'b0;
        settle(); chk({lsd, pre, nak}, 3'b000);
        $display("test host done");
    endtask

    // stall event, masked then unmasked interrupt, read clears
    task automatic t_stall();
        // suspend and halt entries from the config test are still pending
        apb(1'b0, INT_STAT_OFS, 32'h0); chk(rd, 32'h05);
        @(posedge pclk); stall_go <= 1'b1; stall_ep <= 4'h5; @(posedge pclk); stall_go <= 1'b0;
        settle(); chk(irq, 1'b0);
        apb(1'b0, 8'h54, 32'h0); chk(rd, 32'h02);
        apb(1'b1, INT_MASK_OFS, 32'h02); settle(); chk(irq, 1'b1);
        apb(1'b0, INT_STAT_OFS, 32'h0); chk(rd, 32'h02);
        settle(); chk(irq, 1'b0);
        // a stall while unmasked raises the interrupt directly
        @(posedge pclk); stall_go <= 1'b1; stall_ep <= 4'h3; @(posedge pclk); stall_go <= 1'b0;
        settle(); chk(irq, 1'b1);
        apb(1'b0, 8'h4C, 32'h0); chk(rd, 32'h02);
        apb(1'b0, INT_STAT_OFS, 32'h0); chk(rd, 32'h02);
        settle(); chk(irq, 1'b0);
        apb(1'b0, 8'h20, 32'h0); chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test stall done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_cfg();
        t_ep();
        t_host();
        t_stall();
        end_of_test();
    end
endmodule
